// *** rtl/hgc_defines.svh ***
// Offsets, field positions, reset values and timing of the headphone gain control.
// Assumes a 100 MHz core clock; included by bare name by the channel and top design files.
`ifndef HGC_DEFINES_SVH
`define HGC_DEFINES_SVH
`define HGC_OFS_LCTRL      8'h00
`define HGC_OFS_RCTRL      8'h04
`define HGC_OFS_TRIM       8'h08
`define HGC_OFS_MODE       8'h0c
`define HGC_OFS_KEY        8'h10
`define HGC_OFS_STAT       8'h14
// Main amplifier control word fields
`define HGC_CB_AMP_EN      0
`define HGC_CB_OUT_EN      1
`define HGC_CB_RAMP_EN     2
`define HGC_CB_ZC_EN       3
`define HGC_CB_MUTE        4
`define HGC_CB_MIN_GAIN    5
`define HGC_CB_GAIN_LSB    8
// Fine trim word: left at bit 0, right at bit 4; enable then 2-bit gain
`define HGC_TB_STRIDE      4
`define HGC_TB_GAIN_LSB    1
`define HGC_MB_DIFF        0
`define HGC_MB_RAIL        1
`define HGC_SUPPLY_KEY     8'hc3
`define HGC_GAIN_MIN       6'h15
`define HGC_GAIN_RST       6'h15
`define HGC_TRIM_MAX       2'h2
`define HGC_ZC_TIMEOUT_NS  100000000
`define HGC_CLK_PERIOD_NS  10
`define HGC_ZC_TIMEOUT_CYC (`HGC_ZC_TIMEOUT_NS / `HGC_CLK_PERIOD_NS)
`define HGC_RAMP_STEP_CYC  64
`endif

// *** rtl/hgc_pkg.sv ***
// Types shared by the headphone gain control files.
// Assumes nothing beyond a SystemVerilog compiler.
package hgc_pkg;
    typedef struct packed {
        logic       min_gain;
        logic       mute;
        logic       zc_en;
        logic       ramp_en;
        logic       out_en;
        logic       amp_en;
        logic [5:0] gain;
    } hgc_ctrl_s;

    typedef struct packed {
        logic       en;
        logic [1:0] gain;
    } hgc_trim_s;

    typedef struct packed {
        logic       amp_en;
        logic       out_en;
        logic       mute;
        logic       fine_en;
        logic [1:0] fine_gain;
        logic [5:0] gain;
        logic [1:0] sub;
    } hgc_drive_s;

    typedef enum logic [1:0] {
        HGC_IDLE = 2'b00,
        HGC_RAMP = 2'b01,
        HGC_ZCW  = 2'b11
    } hgc_state_e;
endpackage : hgc_pkg

// *** rtl/hgc_channel.sv ***
// One channel's main amplifier gain engine: direct, ramped or zero-cross updates.
// Assumes control from same-clock registers; the zero-cross pin is asynchronous.
`include "hgc_defines.svh"
module hgc_channel #(
    parameter int TIMEOUT_CYC = `HGC_ZC_TIMEOUT_CYC,
    parameter int STEP_CYC    = `HGC_RAMP_STEP_CYC
) (
    input  wire logic              clk_in,
    input  wire logic              rst_n_in,
    input  wire hgc_pkg::hgc_ctrl_s ctrl_in,
    input  wire logic              zc_pin_in,
    output logic [5:0]             gain_out,
    output logic [1:0]             sub_out,
    output logic                   busy_out
);
    import hgc_pkg::*;
    localparam int TW = $clog2(TIMEOUT_CYC + STEP_CYC + 1);

    hgc_state_e  state_ff, nxt_state;
    logic [5:0]  gain_ff, nxt_gain;
    logic [1:0]  sub_ff, nxt_sub;
    logic        dir_ff, nxt_dir;
    logic [TW-1:0] timer_ff, nxt_timer;
    logic        meta_ff, sync_ff, sign_ff;

    // Reserved codes clamp to the lowest gain; see RULE19
    wire [5:0] clamped  = (ctrl_in.gain < `HGC_GAIN_MIN) ? `HGC_GAIN_MIN : ctrl_in.gain;
    wire [5:0] target   = ctrl_in.min_gain ? `HGC_GAIN_MIN : clamped; // see RULE14 see RULE15
    wire       differ   = target != gain_ff;
    wire       zc_seen  = sync_ff != sign_ff;
    wire       tick     = timer_ff == TW'(STEP_CYC - 1);
    wire       expire   = timer_ff == TW'(TIMEOUT_CYC - 1);
    wire [5:0] stepped  = dir_ff ? gain_ff + 6'h01 : gain_ff - 6'h01;

    always_comb begin
        nxt_state = state_ff;
        nxt_gain  = gain_ff;
        nxt_sub   = sub_ff;
        nxt_dir   = dir_ff;
        nxt_timer = '0;
        case (state_ff)
            HGC_IDLE: begin
                if (differ && ctrl_in.ramp_en) begin
                    nxt_state = HGC_RAMP;            // see RULE9
                end else if (differ && ctrl_in.zc_en) begin
                    nxt_state = HGC_ZCW;
                end else begin
                    nxt_gain = target;
                end
            end
            HGC_RAMP: begin
                if (!tick) begin
                    nxt_timer = timer_ff + TW'(1);
                end else if (sub_ff == 2'h3) begin
                    nxt_sub  = 2'h0;
                    nxt_gain = stepped;              // see RULE8
                end else if (sub_ff == 2'h0 && !differ) begin
                    nxt_state = HGC_IDLE;
                end else begin
                    if (sub_ff == 2'h0) begin
                        nxt_dir = target > gain_ff;
                    end
                    nxt_sub = sub_ff + 2'h1;         // see RULE10
                end
            end
            HGC_ZCW: begin
                if (ctrl_in.ramp_en) begin
                    nxt_state = HGC_RAMP;            // see RULE9
                end else if (zc_seen || expire || !ctrl_in.zc_en) begin
                    nxt_gain  = target;              // see RULE11 see RULE12
                    nxt_state = HGC_IDLE;
                end else begin
                    nxt_timer = timer_ff + TW'(1);
                end
            end
            default: begin
                nxt_state = HGC_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= HGC_IDLE;
            gain_ff  <= `HGC_GAIN_RST;
            sub_ff   <= 2'h0;
            dir_ff   <= 1'b0;
            timer_ff <= '0;
            meta_ff  <= 1'b0;
            sync_ff  <= 1'b0;
            sign_ff  <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            gain_ff  <= nxt_gain;
            sub_ff   <= nxt_sub;
            dir_ff   <= nxt_dir;
            timer_ff <= nxt_timer;
            meta_ff  <= zc_pin_in;
            sync_ff  <= meta_ff;
            sign_ff  <= sync_ff;
        end
    end

    assign gain_out = gain_ff;
    assign sub_out  = sub_ff;
    assign busy_out = state_ff != HGC_IDLE;

    property p_ramp_step;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_ff == HGC_RAMP && tick && sub_ff == 2'h3)
            |=> (gain_ff == $past(gain_ff) + 6'h01 || gain_ff == $past(gain_ff) - 6'h01);
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("ramp moved more than one code"); // see RULE8
    property p_ramp_wins;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_ff == HGC_IDLE && differ && ctrl_in.ramp_en && ctrl_in.zc_en)
            |=> (state_ff == HGC_RAMP) ##1 (gain_ff == $past(gain_ff));
    endproperty
    a_ramp_wins: assert property (p_ramp_wins) else $error("ramp did not override zero cross"); // see RULE9
    property p_sub_only_ramp;
        @(posedge clk_in) disable iff (!rst_n_in)
        (sub_ff != 2'h0) |-> (state_ff == HGC_RAMP);
    endproperty
    a_sub_only_ramp: assert property (p_sub_only_ramp) else $error("sub step outside ramp"); // see RULE10
    property p_zc_hold;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_ff == HGC_ZCW && !zc_seen && !expire && ctrl_in.zc_en && !ctrl_in.ramp_en)
            |=> $stable(gain_ff);
    endproperty
    a_zc_hold: assert property (p_zc_hold) else $error("gain changed before zero cross"); // see RULE11
    property p_timeout;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_ff == HGC_ZCW && expire && !ctrl_in.ramp_en) |=> (state_ff == HGC_IDLE);
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout did not apply gain"); // see RULE12
    property p_min_direct;
        @(posedge clk_in) disable iff (!rst_n_in)
        (state_ff == HGC_IDLE && ctrl_in.min_gain && !ctrl_in.ramp_en && !ctrl_in.zc_en)
            |=> (gain_ff == `HGC_GAIN_MIN);
    endproperty
    a_min_direct: assert property (p_min_direct) else $error("minimum gain not applied"); // see RULE14
    property p_no_reserved;
        @(posedge clk_in) disable iff (!rst_n_in)
        (gain_ff >= `HGC_GAIN_MIN);
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("reserved gain code applied"); // see RULE19
endmodule : hgc_channel

// *** rtl/hgc_top.sv ***
// Headphone gain control: AHB-Lite register slave, two gain engines, drive outputs.
// Assumes one 100 MHz clock, single word transfers, and asynchronous zero-cross pins.
//
// Contract
// RULE1: Fine trim enabled by bit, -1..0 dB
// RULE2: Fine trim change applies at once
// RULE3: Right fine trim mirrors left, own controls
// RULE4: Software sets differential mode before use
// RULE5: Single-rail bit writable after key 0xC3
// RULE6: Amplifier and output stage enabled separately
// RULE7: Six-bit code, 1.5 dB steps, -57..+6
// RULE8: Ramp walks through every intermediate code
// RULE9: Ramp overrides zero-cross synchronisation
// RULE10: Ramp adds finer sub-steps between codes
// RULE11: Zero-cross mode holds change until crossing
// RULE12: Fixed 0.1 s timeout applies pending change
// RULE13: Mute bit silences main amplifier
// RULE14: Minimum-gain bit forces lowest gain
// RULE15: Minimum gain uses ramp or zero-cross
// RULE16: Right main amplifier mirrors left, own controls
// RULE17: Combined path -58..+6 dB, 0.5 dB
// RULE18: Non-key write keeps single-rail bit locked
// RULE19: Reserved main gain codes clamp to -57
`include "hgc_defines.svh"
module hgc_top #(
    parameter int ZC_TIMEOUT_CYC = `HGC_ZC_TIMEOUT_CYC,
    parameter int RAMP_STEP_CYC  = `HGC_RAMP_STEP_CYC
) (
    input  wire logic                    clk_in,
    input  wire logic                    rst_n_in,
    input  wire logic                    hsel_in,
    input  wire logic [31:0]             haddr_in,
    input  wire logic [1:0]              htrans_in,
    input  wire logic                    hwrite_in,
    input  wire logic [2:0]              hsize_in,
    input  wire logic [31:0]             hwdata_in,
    input  wire logic                    hready_in,
    output logic                         hreadyout_out,
    output logic [31:0]                  hrdata_out,
    output logic                         hresp_out,
    input  wire logic [1:0]              zc_pin_in,
    output hgc_pkg::hgc_drive_s [1:0]    drive_out,
    output logic                         differential_output_select_out,
    output logic                         single_rail_select_out
);
    import hgc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus address phase

    logic [7:0]  addr_ff;
    logic        wr_pend_ff;
    logic        rd_pend_ff;
    logic        hreadyout_ff;
    logic [31:0] hrdata_ff;

    wire        take     = hsel_in && hready_in && htrans_in[1];
    wire        in_range = haddr_in[31:8] == 24'h0;
    wire        word_ok  = hsize_in == 3'h2;
    // Anything outside the map decodes to an address that matches no register
    wire [7:0]  nxt_addr = (in_range && word_ok) ? haddr_in[7:0] : 8'hff;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_ff    <= 8'hff;
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
        end else begin
            if (take) begin
                addr_ff <= nxt_addr;
            end
            wr_pend_ff <= take && hwrite_in;
            rd_pend_ff <= take && !hwrite_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write decode

    wire wr_trim = wr_pend_ff && addr_ff == `HGC_OFS_TRIM;
    wire wr_mode = wr_pend_ff && addr_ff == `HGC_OFS_MODE;
    wire wr_key  = wr_pend_ff && addr_ff == `HGC_OFS_KEY;
    wire key_hit = hwdata_in[7:0] == `HGC_SUPPLY_KEY;

    ////////////////////////////////////////////////////////////////////////////////
    // Supply mode and key

    logic diff_ff;
    logic rail_ff;
    logic unlock_ff;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            diff_ff   <= 1'b0;
            rail_ff   <= 1'b0;
            unlock_ff <= 1'b0;
        end else begin
            if (wr_mode) begin
                diff_ff <= hwdata_in[`HGC_MB_DIFF];   // see RULE4
            end
            if (wr_mode && unlock_ff) begin
                rail_ff <= hwdata_in[`HGC_MB_RAIL];   // see RULE5
            end
            // One key opens one write; a wrong key or any mode write relocks
            if (wr_key) begin
                unlock_ff <= key_hit;                 // see RULE5 see RULE18
            end else if (wr_mode) begin
                unlock_ff <= 1'b0;                    // see RULE18
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Per channel registers, engines and drive

    hgc_ctrl_s   ctrl_ff  [2];
    hgc_trim_s   trim_ff  [2];
    hgc_drive_s  drive_ff [2];
    logic [5:0]  eng_gain [2];
    logic [1:0]  eng_sub  [2];
    logic        eng_busy [2];
    logic [7:0]  total    [2];
    logic [1:0]  busy_ff;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            localparam logic [7:0] OFS = `HGC_OFS_LCTRL + 8'(4 * ch);
            localparam int         TB  = `HGC_TB_STRIDE * ch;

            wire       wr_ctrl  = wr_pend_ff && addr_ff == OFS;
            wire [1:0] trim_raw = hwdata_in[TB + `HGC_TB_GAIN_LSB +: 2];
            // Spare trim code has no meaning; clamp it to 0 dB
            wire [1:0] trim_new = (trim_raw > `HGC_TRIM_MAX) ? `HGC_TRIM_MAX : trim_raw;
            // Half-dB steps above -58 dB: three per main code plus the trim
            wire [7:0] main_idx = {2'h0, eng_gain[ch]} - {2'h0, `HGC_GAIN_MIN};

            assign total[ch] = 8'(main_idx * 8'h03) + {6'h0, drive_ff[ch].fine_gain}; // see RULE17

            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    ctrl_ff[ch] <= '{gain: `HGC_GAIN_RST, default: 1'b0};
                end else if (wr_ctrl) begin
                    ctrl_ff[ch].amp_en   <= hwdata_in[`HGC_CB_AMP_EN];   // see RULE6
                    ctrl_ff[ch].out_en   <= hwdata_in[`HGC_CB_OUT_EN];   // see RULE6
                    ctrl_ff[ch].ramp_en  <= hwdata_in[`HGC_CB_RAMP_EN];
                    ctrl_ff[ch].zc_en    <= hwdata_in[`HGC_CB_ZC_EN];
                    ctrl_ff[ch].mute     <= hwdata_in[`HGC_CB_MUTE];
                    ctrl_ff[ch].min_gain <= hwdata_in[`HGC_CB_MIN_GAIN];
                    ctrl_ff[ch].gain     <= hwdata_in[`HGC_CB_GAIN_LSB +: 6]; // see RULE7
                end
            end

            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    trim_ff[ch] <= '0;
                end else if (wr_trim) begin
                    trim_ff[ch].en   <= hwdata_in[TB];     // see RULE1 see RULE3
                    trim_ff[ch].gain <= trim_new;          // see RULE1 see RULE3
                end
            end

            // Same engine for both sides keeps left and right identical
            hgc_channel #(
                .TIMEOUT_CYC (ZC_TIMEOUT_CYC),
                .STEP_CYC    (RAMP_STEP_CYC)
            ) u_chan (
                .clk_in    (clk_in),
                .rst_n_in  (rst_n_in),
                .ctrl_in   (ctrl_ff[ch]),
                .zc_pin_in (zc_pin_in[ch]),
                .gain_out  (eng_gain[ch]),
                .sub_out   (eng_sub[ch]),
                .busy_out  (eng_busy[ch])
            ); // see RULE16

            // Trim goes straight through, no zero-cross wait and no ramp
            always_ff @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    drive_ff[ch] <= '{gain: `HGC_GAIN_RST, default: 1'b0};
                    busy_ff[ch]  <= 1'b0;
                end else begin
                    drive_ff[ch].amp_en    <= ctrl_ff[ch].amp_en;   // see RULE6
                    drive_ff[ch].out_en    <= ctrl_ff[ch].out_en;   // see RULE6
                    drive_ff[ch].mute      <= ctrl_ff[ch].mute;     // see RULE13
                    drive_ff[ch].fine_en   <= trim_ff[ch].en;       // see RULE1
                    drive_ff[ch].fine_gain <= trim_ff[ch].gain;     // see RULE2
                    drive_ff[ch].gain      <= eng_gain[ch];         // see RULE7
                    drive_ff[ch].sub       <= eng_sub[ch];          // see RULE10
                    busy_ff[ch]            <= eng_busy[ch];
                end
            end

            assign drive_out[ch] = drive_ff[ch];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Read data

    wire [31:0] rd_lctrl = {18'h0, ctrl_ff[0].gain, 2'h0,
                            ctrl_ff[0].min_gain, ctrl_ff[0].mute, ctrl_ff[0].zc_en,
                            ctrl_ff[0].ramp_en, ctrl_ff[0].out_en, ctrl_ff[0].amp_en};
    wire [31:0] rd_rctrl = {18'h0, ctrl_ff[1].gain, 2'h0,
                            ctrl_ff[1].min_gain, ctrl_ff[1].mute, ctrl_ff[1].zc_en,
                            ctrl_ff[1].ramp_en, ctrl_ff[1].out_en, ctrl_ff[1].amp_en};
    wire [31:0] rd_trim  = {25'h0, trim_ff[1].gain, trim_ff[1].en,
                            1'b0, trim_ff[0].gain, trim_ff[0].en};
    wire [31:0] rd_mode  = {30'h0, rail_ff, diff_ff};
    wire [31:0] rd_key   = {31'h0, unlock_ff};
    // Status shows applied state, not the requested settings
    wire [31:0] rd_stat  = {14'h0, busy_ff, total[1], total[0]};

    wire [31:0] rd_mux =
        (addr_ff == `HGC_OFS_LCTRL) ? rd_lctrl :
        (addr_ff == `HGC_OFS_RCTRL) ? rd_rctrl :
        (addr_ff == `HGC_OFS_TRIM)  ? rd_trim  :
        (addr_ff == `HGC_OFS_MODE)  ? rd_mode  :
        (addr_ff == `HGC_OFS_KEY)   ? rd_key   :
        (addr_ff == `HGC_OFS_STAT)  ? rd_stat  : 32'h0;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus data phase
    // Reads take one wait state so a write just before is already visible

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hreadyout_ff <= 1'b1;
            hrdata_ff    <= 32'h0;
        end else begin
            if (take && !hwrite_in) begin
                hreadyout_ff <= 1'b0;
            end else if (rd_pend_ff) begin
                hreadyout_ff <= 1'b1;
                hrdata_ff    <= rd_mux;
            end
        end
    end

    assign hreadyout_out                   = hreadyout_ff;
    assign hrdata_out                      = hrdata_ff;
    assign hresp_out                       = 1'b0;
    assign differential_output_select_out  = diff_ff;
    assign single_rail_select_out          = rail_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_locked;
        @(posedge clk_in) disable iff (!rst_n_in)
        (wr_mode && !unlock_ff) |=> $stable(rail_ff) && !unlock_ff;
    endproperty
    a_locked: assert property (p_locked) else $error("locked supply bit changed"); // see RULE18

    property p_relock;
        @(posedge clk_in) disable iff (!rst_n_in)
        (wr_key && !key_hit) |=> !unlock_ff;
    endproperty
    a_relock: assert property (p_relock) else $error("wrong key unlocked"); // see RULE18

    property p_rail_open;
        @(posedge clk_in) disable iff (!rst_n_in)
        (wr_mode && unlock_ff)
            |=> (rail_ff == $past(hwdata_in[`HGC_MB_RAIL])) && !unlock_ff;
    endproperty
    a_rail_open: assert property (p_rail_open) else $error("rail bit lost"); // see RULE5

    property p_diff;
        @(posedge clk_in) disable iff (!rst_n_in)
        wr_mode |=> (diff_ff == $past(hwdata_in[`HGC_MB_DIFF]));
    endproperty
    a_diff: assert property (p_diff) else $error("mode bit not stored"); // see RULE4

    property p_unlock;
        @(posedge clk_in) disable iff (!rst_n_in)
        (wr_key && key_hit) |=> unlock_ff;
    endproperty
    a_unlock: assert property (p_unlock) else $error("key did not unlock"); // see RULE5

    property p_fine_now;
        @(posedge clk_in) disable iff (!rst_n_in)
        wr_trim |=> ##1 (drive_ff[0].fine_gain == $past(trim_ff[0].gain)
                         && drive_ff[1].fine_gain == $past(trim_ff[1].gain));
    endproperty
    a_fine_now: assert property (p_fine_now) else $error("fine trim delayed"); // see RULE2

    property p_fine_en;
        @(posedge clk_in) disable iff (!rst_n_in)
        wr_trim |=> ##1 (drive_ff[0].fine_en == $past(trim_ff[0].en)
                         && drive_ff[1].fine_en == $past(trim_ff[1].en));
    endproperty
    a_fine_en: assert property (p_fine_en) else $error("fine enable delayed"); // see RULE1

    property p_trim_legal;
        @(posedge clk_in) disable iff (!rst_n_in)
        wr_trim |=> (trim_ff[0].gain <= `HGC_TRIM_MAX)
                    && (trim_ff[1].gain <= `HGC_TRIM_MAX);
    endproperty
    a_trim_legal: assert property (p_trim_legal) else $error("trim code 3 kept"); // see RULE3

    property p_read_wait;
        @(posedge clk_in) disable iff (!rst_n_in)
        (take && !hwrite_in) |=> !hreadyout_ff ##1 hreadyout_ff;
    endproperty
    a_read_wait: assert property (p_read_wait) else $error("read answer timing wrong");

    property p_write_fast;
        @(posedge clk_in) disable iff (!rst_n_in)
        (take && hwrite_in) |=> hreadyout_ff;
    endproperty
    a_write_fast: assert property (p_write_fast) else $error("write stalled");

    property p_mute;
        @(posedge clk_in) disable iff (!rst_n_in)
        (ctrl_ff[0].mute || ctrl_ff[1].mute)
            |=> (drive_ff[0].mute == $past(ctrl_ff[0].mute))
                && (drive_ff[1].mute == $past(ctrl_ff[1].mute));
    endproperty
    a_mute: assert property (p_mute) else $error("mute not driven"); // see RULE13

    property p_enables;
        @(posedge clk_in) disable iff (!rst_n_in)
        ctrl_ff[1].amp_en
            |=> drive_ff[1].amp_en && (drive_ff[1].out_en == $past(ctrl_ff[1].out_en));
    endproperty
    a_enables: assert property (p_enables) else $error("stage enables lost"); // see RULE6
endmodule : hgc_top

// *** tb/tb.sv ***
// Self-checking bench for the headphone gain control top level.
// Assumes the small counts ZC_TIMEOUT_CYC 200 and RAMP_STEP_CYC 4, one 100 MHz clock.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import hgc_pkg::*;

    typedef struct {
        logic [31:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } hgc_row_s;

    logic               clk_in;
    logic               rst_n_in;
    logic               hsel_in;
    logic               hwrite_in;
    logic               hready;
    logic               hresp_out;
    logic               diff_out;
    logic               rail_out;
    logic [1:0]         htrans_in;
    logic [1:0]         zc_pin_in;
    logic [2:0]         hsize_in;
    logic [31:0]        haddr_in;
    logic [31:0]        hwdata_in;
    logic [31:0]        hrdata_out;
    logic [31:0]        rd;
    hgc_drive_s [1:0]   drive_out;
    int                 mismatches;
    int                 compares;
    int                 n;
    logic               sub_seen;
    // Order matters: the key is single use and a mode write relocks
    hgc_row_s rows[11] = '{
        '{32'h0c, 32'h03, 32'h01}, '{32'h08, 32'h77, 32'h55}, '{32'h00, 32'h3b03, 32'h3b03},
        '{32'h04, 32'h2f13, 32'h2f13}, '{32'h20, 32'hff, 32'h00}, '{32'h10, 32'hc3, 32'h01},
        '{32'h0c, 32'h03, 32'h03}, '{32'h10, 32'h12, 32'h00}, '{32'h0c, 32'h01, 32'h03},
        '{32'h10, 32'hc3, 32'h01}, '{32'h0c, 32'h01, 32'h01}};

    hgc_top #(.ZC_TIMEOUT_CYC(200), .RAMP_STEP_CYC(4)) dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
        .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in),
        .hwdata_in(hwdata_in), .hready_in(hready), .hreadyout_out(hready),
        .hrdata_out(hrdata_out), .hresp_out(hresp_out), .zc_pin_in(zc_pin_in),
        .drive_out(drive_out), .differential_output_select_out(diff_out),
        .single_rail_select_out(rail_out));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask : chk

    // One single AHB-Lite word transfer; the wait ends only on hready
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        htrans_in <= 2'h2;
        haddr_in  <= a;
        hwrite_in <= w;
        do @(posedge clk_in); while (hready !== 1'b1);
        htrans_in <= 2'h0;
        if (w) hwdata_in <= d;
        do @(posedge clk_in); while (hready !== 1'b1);
        r = hrdata_out;
    endtask : bus

    // Waits for the left applied gain; in ramp mode every change must be one code up
    task automatic settle(input logic [5:0] target, input bit ramp, output int cyc);
        logic [5:0] prev;
        prev = drive_out[0].gain;
        cyc = 0;
        while (drive_out[0].gain !== target && cyc < 400) begin
            @(posedge clk_in);
            cyc++;
            if (drive_out[0].sub !== 2'h0) sub_seen = 1'b1;
            if (ramp && drive_out[0].gain !== prev) chk(drive_out[0].gain, prev + 6'h1, "ramp step");
            prev = drive_out[0].gain;
        end
        chk(drive_out[0].gain, target, "settled gain");
    endtask : settle

    task automatic tally_and_finish;
        $display("counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    initial begin
        repeat (20000) @(posedge clk_in);
        mismatches++;
        tally_and_finish();
    end

    initial begin
        {rst_n_in, hsel_in, hwrite_in, htrans_in, zc_pin_in, haddr_in, hwdata_in} = '0;
        hsize_in = 3'h2;
        mismatches = 0;
        compares = 0;
        sub_seen = 1'b0;
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        hsel_in  <= 1'b1;
        @(posedge clk_in);
        chk({hready, diff_out, rail_out, drive_out[0].gain}, {3'b100, 6'h15}, "reset");
        $display("test done: reset values");
        foreach (rows[i]) begin
            bus(1'b1, rows[i].a, rows[i].d, rd);
            bus(1'b0, rows[i].a, 32'h0, rd);
            chk(rd, rows[i].e, "register row");
        end
        chk({diff_out, rail_out, hresp_out}, 3'b100, "mode pins");
        $display("test done: register table");
        repeat (4) @(posedge clk_in);
        chk(drive_out[0], {4'b1101, 2'h2, 6'h3b, 2'h0}, "left drive");
        chk(drive_out[1], {4'b1111, 2'h2, 6'h2f, 2'h0}, "right drive");
        bus(1'b0, 32'h14, 32'h0, rd);
        chk(rd, 32'h0000_5074, "path totals");
        bus(1'b1, 32'h00, 32'h1003, rd);
        repeat (4) @(posedge clk_in);
        chk(drive_out[0].gain, 6'h15, "reserved code");
        bus(1'b1, 32'h00, 32'h3b23, rd);
        repeat (4) @(posedge clk_in);
        chk(drive_out[0].gain, 6'h15, "forced lowest");
        $display("test done: direct gain");
        // Ramp with zero-cross also set: the timeout must not be what moves it
        bus(1'b1, 32'h00, 32'h180f, rd);
        settle(6'h18, 1'b1, n);
        chk(n < 100, 1'b1, "ramp ignored zero-cross");
        chk(sub_seen, 1'b1, "sub steps");
        $display("test done: ramp");
        bus(1'b1, 32'h00, 32'h3b0b, rd);
        repeat (20) @(posedge clk_in);
        chk(drive_out[0].gain, 6'h18, "held for crossing");
        zc_pin_in[0] <= 1'b1;
        settle(6'h3b, 1'b0, n);
        chk(n < 10, 1'b1, "crossing latency");
        bus(1'b1, 32'h00, 32'h200b, rd);
        settle(6'h20, 1'b0, n);
        chk(n > 190 && n < 210, 1'b1, "timeout span");
        bus(1'b1, 32'h00, 32'h202b, rd);
        repeat (20) @(posedge clk_in);
        chk(drive_out[0].gain, 6'h20, "lowest waits");
        zc_pin_in[0] <= 1'b0;
        settle(6'h15, 1'b0, n);
        $display("test done: zero-cross");
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        chk({hready, diff_out, rail_out, drive_out[1]}, 17'h1_0054, "mid-run reset");
        rst_n_in <= 1'b1;
        $display("test done: mid-run reset");
        tally_and_finish();
    end
endmodule : tb
